// *** core/slpg_top.sv ***
`timescale 1ns/1ps
module slpg_top
  import slpg_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES  // Cycles per 62.5 ms tick
)(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire slpg_bus_t   bus,           // Register port request
  input  wire logic        pwr_state_on,  // Power state status level
  input  wire logic        otp_prog_err,  // Memory programming error level
  output logic [15:0]      rd_data,       // Read data, cycle after strobe
  output logic             lamp_out       // Indicator drive, high lights
);

  //====================================================================
  // Decode helpers
  function automatic logic [7:0] on_ticks(input logic [1:0] dur);
    case (dur)
      2'b00:   on_ticks = TICKS_1S;
      2'b01:   on_ticks = TICKS_250MS;
      2'b10:   on_ticks = TICKS_125MS;
      default: on_ticks = TICKS_62MS;
    endcase
  endfunction

  // Largest result is 16 x 7 = 112, fits eight bits
  function automatic logic [7:0] off_ticks(input logic [7:0] on, input logic [1:0] ratio);
    case (ratio)
      2'b00:   off_ticks = on;
      2'b01:   off_ticks = on + on;
      2'b10:   off_ticks = on + on + on;
      default: off_ticks = (on << 3) - on;
    endcase
  endfunction

  function automatic logic [2:0] burst_len(input logic [1:0] code);
    case (code)
      2'b00:   burst_len = 3'h1;
      2'b01:   burst_len = 3'h2;
      2'b10:   burst_len = 3'h4;
      default: burst_len = 3'h7;
    endcase
  endfunction

  //====================================================================
  // Storage
  slpg_ctrl_t  ctrl;       // Control register
  slpg_state_t state;      // Pattern phase
  logic [7:0]  remain;     // Ticks left in phase
  logic [2:0]  pulses;     // Pulses done in burst
  logic [22:0] div_cnt;    // Tick divider
  logic        tick;       // One-cycle tick enable
  logic        pulsing;    // Engine should run
  logic        bursting;   // Burst pattern active
  logic [7:0]  cur_on;     // On ticks in force
  logic [7:0]  cur_off;    // Off ticks in force
  logic [2:0]  cur_len;    // Burst length in force
  logic        next_lamp;  // Lamp value for next cycle

  //====================================================================
  // Effective pattern; error blink overrides every setting
  always_comb
  begin
    pulsing  = otp_prog_err
             || (ctrl.lamp_source_select == SRC_MANUAL
                 && (ctrl.lamp_manual_pattern == PAT_PULSE
                     || ctrl.lamp_manual_pattern == PAT_BURST));
    bursting = !otp_prog_err && ctrl.lamp_source_select == SRC_MANUAL
             && ctrl.lamp_manual_pattern == PAT_BURST;
    cur_on   = otp_prog_err ? ERR_ON_TICKS : on_ticks(ctrl.lamp_on_duration);
    cur_off  = otp_prog_err ? ERR_ON_TICKS
                            : off_ticks(cur_on, ctrl.lamp_on_off_ratio);
    cur_len  = burst_len(ctrl.lamp_burst_count);
  end

  //====================================================================
  // Register writes; reserved bits never stored, so they read zero
  always_ff @(posedge clk)
  begin
    if (!nrst)
      ctrl <= CTRL_RESET;
    else if (bus.wr && bus.addr == LAMP_CTRL_ADDR)
      ctrl <= slpg_ctrl_t'(bus.wdata & CTRL_WMASK);
  end

  // Register reads; data valid only the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rd_data <= 16'h0000;
    else if (bus.rd && bus.addr == LAMP_CTRL_ADDR)
      rd_data <= ctrl;
    else if (bus.rd && bus.addr == LAMP_STAT_ADDR)
      rd_data <= {10'h000, lamp_out, pulses, state};
    else
      rd_data <= 16'h0000;  // Unmapped address or no read
  end

  //====================================================================
  // Tick divider; held while idle so the first pulse is full length
  always_ff @(posedge clk)
  begin
    if (!nrst || state == ST_IDLE || tick)
      div_cnt <= 23'h00_0000;
    else
      div_cnt <= div_cnt + 23'h00_0001;
  end

  assign tick = (div_cnt == 23'(TICK_LEN - 1));

  //====================================================================
  // Pattern sequencer; new settings take hold at the next phase load
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state  <= ST_IDLE;
      remain <= 8'h00;
      pulses <= PULSE_ZERO;
    end
    else if (!pulsing)
    begin
      state  <= ST_IDLE;  // Pattern left pulsing, park
      remain <= 8'h00;
      pulses <= PULSE_ZERO;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          state  <= ST_ON;  // Start with a lit phase
          remain <= cur_on;
          pulses <= PULSE_ZERO;
        end
        ST_ON:
          if (tick && remain == ONE_TICK)
          begin
            state  <= ST_OFF;
            remain <= cur_off;
            // Counted only in a burst, so a switch from pulsing starts a clean burst
            pulses <= bursting ? pulses + 3'h1 : PULSE_ZERO;
          end
          else if (tick)
            remain <= remain - ONE_TICK;
        ST_OFF:
          if (tick && remain == ONE_TICK)
          begin
            if (bursting && pulses >= cur_len)
            begin
              state  <= ST_GAP;  // Burst complete
              remain <= GAP_TICKS;
            end
            else
            begin
              state  <= ST_ON;
              remain <= cur_on;
            end
          end
          else if (tick)
            remain <= remain - ONE_TICK;
        ST_GAP:
          if (tick && remain == ONE_TICK)
          begin
            state  <= ST_ON;  // Repeat the burst
            remain <= cur_on;
            pulses <= PULSE_ZERO;
          end
          else if (tick)
            remain <= remain - ONE_TICK;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  //====================================================================
  // Lamp selection; registered so the pin never glitches
  always_comb
  begin
    if (otp_prog_err)
      next_lamp = (state == ST_ON);
    else
      case (ctrl.lamp_source_select)
        SRC_STATUS: next_lamp = pwr_state_on;
        SRC_MANUAL:
          case (ctrl.lamp_manual_pattern)
            PAT_CONST: next_lamp = 1'b1;
            PAT_PULSE,
            PAT_BURST: next_lamp = (state == ST_ON);
            default:   next_lamp = 1'b0;
          endcase
        default:    next_lamp = 1'b0;  // Off and reserved
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      lamp_out <= 1'b0;
    else
      lamp_out <= next_lamp;
  end

  //====================================================================
  // Checks
  chk_src_off_dark: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl.lamp_source_select == SRC_OFF && !otp_prog_err) |=> !lamp_out)
    else $error("lamp lit while source off");

  chk_src_status_follow: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl.lamp_source_select == SRC_STATUS && !otp_prog_err)
      |=> lamp_out == $past(pwr_state_on))
    else $error("lamp not following power state");

  chk_err_blink_on: assert property (@(posedge clk) disable iff (!nrst)
    (otp_prog_err && state == ST_ON) |=> lamp_out)
    else $error("error blink missing");

  chk_manual_const_on: assert property (@(posedge clk) disable iff (!nrst)
    (!otp_prog_err && ctrl.lamp_source_select == SRC_MANUAL
     && ctrl.lamp_manual_pattern == PAT_CONST) |=> lamp_out)
    else $error("constant pattern not lit");

  chk_pattern_ignored: assert property (@(posedge clk) disable iff (!nrst)
    (!otp_prog_err && ctrl.lamp_source_select != SRC_MANUAL) |=> state == ST_IDLE)
    else $error("pattern running outside manual");

  chk_on_load: assert property (@(posedge clk) disable iff (!nrst)
    (pulsing && state == ST_IDLE) |=> (state == ST_ON && remain == $past(cur_on)))
    else $error("on time loaded wrong");

  chk_off_load: assert property (@(posedge clk) disable iff (!nrst)
    (pulsing && state == ST_ON && tick && remain == ONE_TICK)
      |=> (state == ST_OFF && remain == $past(cur_off)))
    else $error("off time loaded wrong");

  chk_burst_count: assert property (@(posedge clk) disable iff (!nrst)
    (state != ST_GAP ##1 state == ST_GAP) |-> pulses == $past(cur_len))
    else $error("burst length wrong");

  chk_gap_repeat: assert property (@(posedge clk) disable iff (!nrst)
    (pulsing && state == ST_GAP && tick && remain == ONE_TICK)
      |=> (state == ST_ON && pulses == PULSE_ZERO))
    else $error("burst not repeated after gap");

  chk_ctrl_readback: assert property (@(posedge clk) disable iff (!nrst)
    (bus.rd && bus.addr == LAMP_CTRL_ADDR) |=> rd_data == $past(ctrl))
    else $error("control readback wrong");

endmodule

// *** shared/slpg_pkg.sv ***
//======================================================================
// Notes on behaviour
// - Source field picks off, status or manual
// - Programming error overrides with its own blink
// - Manual pattern field acts only in manual
// - Pattern: off, constant, continuous pulse, burst
// - Burst length 1, 2, 4 or 7
// - On time 1s, 250ms, 125ms, 62.5ms
// - Off time is on time times 1,2,3,7
package slpg_pkg;

  //====================================================================
  // Register map
  localparam logic [15:0] LAMP_CTRL_ADDR = 16'h404d;  // Indicator lamp control
  localparam logic [15:0] LAMP_STAT_ADDR = 16'h40f0;  // Pattern engine state, read only

  //====================================================================
  // Field encodings
  typedef enum logic [1:0] {
    SRC_OFF    = 2'b00,  // Lamp forced dark
    SRC_STATUS = 2'b01,  // Lamp follows power state
    SRC_RSVD   = 2'b10,  // Reserved, treated as dark
    SRC_MANUAL = 2'b11   // Manual pattern engine
  } slpg_src_t;

  typedef enum logic [1:0] {
    PAT_OFF   = 2'b00,
    PAT_CONST = 2'b01,
    PAT_PULSE = 2'b10,
    PAT_BURST = 2'b11
  } slpg_pat_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // Engine parked, divider held
    ST_ON   = 2'b01,  // Lit part of a pulse
    ST_OFF  = 2'b10,  // Dark part of a pulse
    ST_GAP  = 2'b11   // Dark pause between bursts
  } slpg_state_t;

  // Control word; reserved gaps keep field positions exact
  typedef struct packed {
    slpg_src_t   lamp_source_select;   // Bits 15:14
    logic [3:0]  rsvd_hi;              // Bits 13:10, read zero
    slpg_pat_t   lamp_manual_pattern;  // Bits 9:8
    logic [1:0]  rsvd_mid;             // Bits 7:6, read zero
    logic [1:0]  lamp_burst_count;     // Bits 5:4
    logic [1:0]  lamp_on_duration;     // Bits 3:2
    logic [1:0]  lamp_on_off_ratio;    // Bits 1:0
  } slpg_ctrl_t;

  // Register port request
  typedef struct packed {
    logic [15:0] addr;   // Register address
    logic [15:0] wdata;  // Write data
    logic        wr;     // One-cycle write strobe
    logic        rd;     // One-cycle read strobe
  } slpg_bus_t;

  localparam slpg_ctrl_t CTRL_RESET = 16'hc026;  // Field defaults
  localparam logic [15:0] CTRL_WMASK = 16'hc33f;  // Writable bits

  //====================================================================
  // Timing; one tick is the shortest on time
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_US       = 62500;  // 62.5 ms
  localparam int TICK_CYCLES   = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam logic [7:0] TICKS_1S     = 8'h10;  // 1 s
  localparam logic [7:0] TICKS_250MS  = 8'h04;
  localparam logic [7:0] TICKS_125MS  = 8'h02;
  localparam logic [7:0] TICKS_62MS   = 8'h01;
  localparam logic [7:0] GAP_TICKS    = 8'h10;  // Pause between bursts
  localparam logic [7:0] ERR_ON_TICKS = 8'h01;  // Error blink, 1:1
  localparam logic [7:0] ONE_TICK     = 8'h01;
  localparam logic [2:0] PULSE_ZERO   = 3'h0;

endpackage

// *** tb/slpg_lamp_model.sv ***
`timescale 1ns/1ps
//==========================================
// Lamp observer: times lit and dark runs
module slpg_lamp_model #(
  parameter int LONG = 32  // Dark run that marks a burst gap
)(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic lamp_out,
  output int        on_len,      // Last lit run, cycles
  output int        off_len,     // Last dark run, cycles
  output int        n_rise,      // Lit edges seen
  output int        last_burst,  // Pulses between two gaps
  output int        n_burst      // Gaps seen
);
  int   run;   // Length of current run
  int   pcnt;  // Pulses since last gap
  logic prev;  // Level one cycle ago

  // Runs are counted in whole cycles, so a lamp is judged as a person sees it
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      run     <= 0;
      prev    <= 1'b0;
      pcnt    <= 0;
      n_rise  <= 0;
      n_burst <= 0;
    end
    else if (lamp_out !== prev)
    begin
      run  <= 1;
      prev <= lamp_out;
      if (lamp_out)
      begin
        off_len <= run;
        n_rise  <= n_rise + 1;
        // Long dark: a burst just ended
        if (run > LONG)
        begin
          last_burst <= pcnt;
          n_burst    <= n_burst + 1;
          pcnt       <= 1;
        end
        else
          pcnt <= pcnt + 1;
      end
      else
        on_len <= run;
    end
    else
      run <= run + 1;
  end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import slpg_pkg::*;
;
  //==========================================
  // Signals
  localparam int TL = 4;  // Short tick keeps the run brief
  logic        clk;
  logic        nrst;
  slpg_bus_t   bus;
  logic        pwr_state_on;
  logic        otp_prog_err;
  logic [15:0] rd_data;
  logic        lamp_out;
  logic [31:0] seed;       // Xorshift state
  logic [31:0] d;          // Random draw
  int          n_errors;
  int          check_count;
  int          cyc;        // Cycle count for the hang guard
  int          on_len, off_len, n_rise, last_burst, n_burst;

  slpg_top #(.TICK_LEN(TL)) uut (.clk(clk), .nrst(nrst), .bus(bus),
    .pwr_state_on(pwr_state_on), .otp_prog_err(otp_prog_err),
    .rd_data(rd_data), .lamp_out(lamp_out));
  slpg_lamp_model lamp (.clk(clk), .nrst(nrst), .lamp_out(lamp_out), .on_len(on_len),
    .off_len(off_len), .n_rise(n_rise), .last_burst(last_burst), .n_burst(n_burst));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  //==========================================
  // Expectations
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int on_cyc(logic [1:0] du);
    int t[4] = '{16, 4, 2, 1};
    return t[du] * TL;
  endfunction
  function automatic int off_cyc(logic [1:0] du, logic [1:0] ra);
    int m[4] = '{1, 2, 3, 7};
    return on_cyc(du) * m[ra];
  endfunction

  //==========================================
  // Checking and bus tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    bus.wr    <= 1'b1;
    bus.addr  <= a;
    bus.wdata <= v;
    @(posedge clk);
    bus.wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd   <= 1'b0;
    #1 chk(rd_data, exp);
  endtask
  task automatic lamp_is(input logic e);
    repeat (3) @(posedge clk);
    #1 chk({15'h0, lamp_out}, {15'h0, e});
  endtask
  // Bounded wait for n more lit edges or gaps
  task automatic wait_ev(input bit gaps, input int n);
    int t0 = gaps ? n_burst : n_rise;
    for (int i = 0; i < 9000 && (gaps ? n_burst : n_rise) < t0 + n; i++)
      @(posedge clk);
    #1;
    // Running out of time counts as a mismatch
    if ((gaps ? n_burst : n_rise) < t0 + n)
      chk(16'((gaps ? n_burst : n_rise) - t0), 16'(n));
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_errors++;
      final_report();
    end
  end

  //==========================================
  // Main sequence
  initial
  begin
    nrst = 1'b0;
    bus = '0;
    pwr_state_on = 1'b0;
    otp_prog_err = 1'b0;
    n_errors = 0;
    check_count = 0;
    cyc = 0;
    seed = 32'h0000_0043;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(LAMP_CTRL_ADDR, CTRL_RESET);
    rd(16'h0000, 16'h0000);
    d = rnd();
    wr(LAMP_CTRL_ADDR, d[15:0]);
    rd(LAMP_CTRL_ADDR, d[15:0] & CTRL_WMASK);
    wr(LAMP_CTRL_ADDR, 16'hc000);
    lamp_is(1'b0);
    $display("register test done");
    // Every source code, pattern constant on
    for (int s = 0; s < 4; s++)
    begin
      wr(LAMP_CTRL_ADDR, {2'(s), 4'h0, PAT_CONST, 8'h26});
      for (int k = 0; k < 2; k++)
      begin
        d = rnd();
        @(posedge clk);
        pwr_state_on <= d[0];
        lamp_is(s == 3 ? 1'b1 : (s == 1 ? d[0] : 1'b0));
      end
    end
    $display("source test done");
    // Every on time against every ratio
    for (int du = 0; du < 4; du++)
      for (int ra = 0; ra < 4; ra++)
      begin
        wr(LAMP_CTRL_ADDR, {SRC_MANUAL, 4'h0, PAT_PULSE, 4'h0, 2'(du), 2'(ra)});
        wait_ev(1'b0, 3);
        chk(16'(on_len), 16'(on_cyc(2'(du))));
        chk(16'(off_len), 16'(off_cyc(2'(du), 2'(ra))));
      end
    $display("pulse test done");
    // Every burst length; third gap closes a clean burst
    for (int c = 0; c < 4; c++)
    begin
      wr(LAMP_CTRL_ADDR, {SRC_MANUAL, 4'h0, PAT_BURST, 2'b00, 2'(c), 4'hc});
      wait_ev(1'b1, 3);
      chk(16'(last_burst), c == 3 ? 16'h0007 : 16'(1 << c));
      chk(16'(off_len), 16'((32'(GAP_TICKS) + 1) * TL));
    end
    $display("burst test done");
    // Programming error overrides a dark source
    wr(LAMP_CTRL_ADDR, 16'h0000);
    @(posedge clk);
    otp_prog_err <= 1'b1;
    wait_ev(1'b0, 3);
    chk(16'(on_len), 16'(32'(ERR_ON_TICKS) * TL));
    chk(16'(off_len), 16'(32'(ERR_ON_TICKS) * TL));
    @(posedge clk);
    otp_prog_err <= 1'b0;
    lamp_is(1'b0);
    $display("error test done");
    // Reset in mid pattern darkens the lamp and restores field defaults
    wr(LAMP_CTRL_ADDR, {SRC_MANUAL, 4'h0, PAT_PULSE, 8'h03});
    wait_ev(1'b0, 1);
    @(posedge clk);
    nrst <= 1'b0;
    lamp_is(1'b0);
    @(posedge clk);
    nrst <= 1'b1;
    rd(LAMP_CTRL_ADDR, CTRL_RESET);
    rd(LAMP_STAT_ADDR, 16'h0000);
    lamp_is(1'b0);
    $display("reset test done");
    final_report();
  end
endmodule
